// *** logic/utf_consts.svh ***
// Constants for the address translation buffers
`ifndef UTF_CONSTS_SVH
`define UTF_CONSTS_SVH
`define UTF_SHARED_ENTRIES 64
`define UTF_FETCH_ENTRIES 4
// Page size codes
`define UTF_SZ_1K 2'h0
`define UTF_SZ_4K 2'h1
`define UTF_SZ_64K 2'h2
`define UTF_SZ_1M 2'h3
// Low frame bits ignored for each page size
`define UTF_MASK_1K 19'h00000
`define UTF_MASK_4K 19'h00003
`define UTF_MASK_64K 19'h0003F
`define UTF_MASK_1M 19'h003FF
// High staging word fields
`define UTF_HI_VFN_MSB 31
`define UTF_HI_VFN_LSB 10
`define UTF_HI_TAG_MSB 7
`define UTF_HI_TAG_LSB 0
// Low staging word fields
`define UTF_LO_PFN_MSB 28
`define UTF_LO_PFN_LSB 10
`define UTF_LO_VALID 8
`define UTF_LO_SIZE_MSB 7
`define UTF_LO_SIZE_LSB 6
`define UTF_LO_AR_MSB 5
`define UTF_LO_AR_LSB 4
`define UTF_LO_CACHE 3
`define UTF_LO_WRITTEN 2
`define UTF_LO_COMMON 1
`define UTF_LO_WT 0
// Assist staging word fields
`define UTF_AS_SA_MSB 3
`define UTF_AS_SA_LSB 1
`define UTF_AS_TS 0
// Address regions
`define UTF_REG_P2 3'h5
`define UTF_REG_P3 3'h6
`define UTF_AREA_5 3'h5
`define UTF_AREA_6 3'h6
`define UTF_SA_UNDEF 3'h0
`define UTF_AGE_RESET 3'h0
`endif

// *** logic/utf_pkg.sv ***
// Types shared by the translation buffer modules
`default_nettype none
package utf_pkg;
  typedef struct packed {
    logic [7:0] tag;
    logic [21:0] vfn;
    logic [18:0] pfn;
    logic [1:0] size;
    logic [1:0] ar;
    logic cacheable;
    logic written;
    logic common;
    logic wt;
    logic [2:0] sa;
    logic ts;
  } utf_entry_type;
  typedef enum logic [1:0] {
    UTF_F_IDLE = 2'b00,
    UTF_F_LOOK = 2'b01,
    UTF_F_REFILL = 2'b10
  } utf_fstate_type;
endpackage
`default_nettype wire

// *** logic/utf_match_if.sv ***
// Signals between a table and one entry comparator
`default_nettype none
interface utf_match_if;
  logic [21:0] look_vfn;
  logic [7:0] look_tag;
  logic use_tag;
  logic valid;
  utf_pkg::utf_entry_type ent;
  logic hit;
  modport cmp (input look_vfn, look_tag, use_tag, valid, ent, output hit);
  modport tab (output look_vfn, look_tag, use_tag, valid, ent, input hit);
endinterface
`default_nettype wire

// *** logic/utf_match.sv ***
// Comparator for one translation entry
`include "utf_consts.svh"
`default_nettype none
module utf_match (
  // Lookup and entry
  utf_match_if.cmp port
);
  logic [18:0] mask;

  // Low frame bits inside the page are not compared
  always_comb begin
    case (port.ent.size)
      `UTF_SZ_1K: mask = `UTF_MASK_1K;
      `UTF_SZ_4K: mask = `UTF_MASK_4K;
      `UTF_SZ_64K: mask = `UTF_MASK_64K;
      default: mask = `UTF_MASK_1M;
    endcase
  end

  // Valid entry, frame agreement and process tag unless shared or use_tag is off
  assign port.hit = port.valid
    && (((port.look_vfn ^ port.ent.vfn) & ~{3'h0, mask}) == 22'h000000)
    && (port.ent.common || !port.use_tag
    || (port.look_tag == port.ent.tag));
endmodule
`default_nettype wire

// *** logic/utf_translate.sv ***
// Shared and fetch translation tables with hardware refill
// How it works
// - Shared table has 64 associative entries
// - Frame compare width follows page size
// - Compare tag when unshared, multi-space or user
// - Shared entries skip the tag compare
// - Size code selects 1k/4k/64k/1M
// - Power-on clears valid, manual reset keeps
// - Physical address merges frame and offset
// - Access right code limits read/write/mode
// - Buffering bit marks page cacheable
// - Each shared entry holds page written
// - Write-through flag picks cache write mode
// - Space attribute applies in areas 5, 6
// - Timing select picks area 5/6 timing
// - Fetch table has 4 associative entries
// - Fetch entries drop written/wt, one right
// - Entry fields steer cache and bus use
// - Untranslatable accesses raise an exception
// - Fetch miss refills from shared table
// - Load op copies staging into pointer slot
// - Fetch table written by refill or array, never by load op
// - Translation only while paging is enabled
// - Space select changes only tag compare
// - Current process tag from high staging
`include "utf_consts.svh"
`default_nettype none
module utf_translate (
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic power_on_clear,
  // Mode and staging
  input wire logic paging_enable_bit,
  input wire logic single_space_select,
  input wire logic user_mode,
  input wire logic [31:0] entry_high_staging,
  input wire logic [31:0] entry_low_staging,
  input wire logic [31:0] entry_assist_staging,
  input wire logic [5:0] replace_pointer,
  input wire logic load_translation_op,
  // Memory-mapped array access
  input wire logic arr_wr,
  input wire logic arr_del,
  input wire logic arr_rd,
  input wire logic arr_fetch,
  input wire logic [5:0] arr_idx,
  input wire logic [31:0] arr_hi,
  input wire logic [31:0] arr_lo,
  input wire logic [31:0] arr_as,
  output logic arr_rd_valid,
  output logic [31:0] arr_rd_hi,
  output logic [31:0] arr_rd_lo,
  output logic [31:0] arr_rd_as,
  // Data access
  input wire logic d_req,
  input wire logic [31:0] d_vaddr,
  input wire logic d_write,
  output logic d_ready,
  output logic d_valid,
  output logic [28:0] d_paddr,
  output logic d_cacheable,
  output logic d_write_through,
  output logic [2:0] d_space_attribute,
  output logic d_timing_select,
  output logic d_miss,
  output logic d_prot_viol,
  output logic d_multi_hit,
  output logic d_first_write,
  // Instruction fetch
  input wire logic f_req,
  input wire logic [31:0] f_vaddr,
  output logic f_ready,
  output logic f_valid,
  output logic [28:0] f_paddr,
  output logic f_cacheable,
  output logic f_miss,
  output logic f_prot_viol,
  output logic f_multi_hit,
  // Status
  output logic [2:0] fetch_table_age_bits,
  output logic mmu_exception
);
  localparam int NS = `UTF_SHARED_ENTRIES;
  localparam int NF = `UTF_FETCH_ENTRIES;

  utf_pkg::utf_entry_type s_tab [NS];
  utf_pkg::utf_entry_type f_tab [NF];
  logic [NS-1:0] s_valid;
  logic [NF-1:0] f_valid_bits;
  logic [NS-1:0] s_hit;
  logic [NF-1:0] f_hit;
  utf_pkg::utf_entry_type stage_ent;
  utf_pkg::utf_entry_type arr_ent;
  utf_pkg::utf_entry_type s_sel;
  utf_pkg::utf_entry_type f_sel;
  utf_pkg::utf_fstate_type fstate;
  logic [31:0] f_addr;
  logic [21:0] s_vfn;
  logic use_tag;
  logic s_none;
  logic s_multi;
  logic f_none;
  logic f_multi;
  logic [1:0] f_idx;
  logic [1:0] victim;
  logic refill_we;
  logic d_take;
  logic f_take;
  logic d_untr;
  logic f_untr;
  logic d_prot;
  logic f_prot;
  logic f_done;

  // Split staging or array words into entry fields
  function automatic utf_pkg::utf_entry_type unpack_words(input logic [31:0] hi,
      input logic [31:0] lo, input logic [31:0] as_w);
    utf_pkg::utf_entry_type e;
    e.tag = hi[`UTF_HI_TAG_MSB:`UTF_HI_TAG_LSB];
    e.vfn = hi[`UTF_HI_VFN_MSB:`UTF_HI_VFN_LSB];
    e.pfn = lo[`UTF_LO_PFN_MSB:`UTF_LO_PFN_LSB];
    e.size = lo[`UTF_LO_SIZE_MSB:`UTF_LO_SIZE_LSB];
    e.ar = lo[`UTF_LO_AR_MSB:`UTF_LO_AR_LSB];
    e.cacheable = lo[`UTF_LO_CACHE];
    e.written = lo[`UTF_LO_WRITTEN];
    e.common = lo[`UTF_LO_COMMON];
    e.wt = lo[`UTF_LO_WT];
    e.sa = as_w[`UTF_AS_SA_MSB:`UTF_AS_SA_LSB];
    e.ts = as_w[`UTF_AS_TS];
    return e;
  endfunction

  // Fetch entries keep no written or write mode bits and one right bit
  function automatic utf_pkg::utf_entry_type fetch_form(input utf_pkg::utf_entry_type e);
    utf_pkg::utf_entry_type r;
    r = e;
    r.written = 1'b0;
    r.wt = 1'b0;
    r.ar[0] = 1'b0;
    return r;
  endfunction

  // Physical address from frame and page offset
  function automatic logic [28:0] phys(input utf_pkg::utf_entry_type e,
      input logic [31:0] va);
    logic [18:0] m;
    case (e.size)
      `UTF_SZ_1K: m = `UTF_MASK_1K;
      `UTF_SZ_4K: m = `UTF_MASK_4K;
      `UTF_SZ_64K: m = `UTF_MASK_64K;
      default: m = `UTF_MASK_1M;
    endcase
    return {(e.pfn & ~m) | (va[28:10] & m), va[9:0]};
  endfunction

  // Regions that bypass the tables while paging is on, and all while it is off
  function automatic logic untranslated(input logic [31:0] va, input logic pe);
    return !pe || (va[31] && (va[31:29] != `UTF_REG_P3));
  endfunction

  // Space attribute and timing only reach card areas
  function automatic logic card_area(input logic [28:0] pa);
    return (pa[28:26] == `UTF_AREA_5) || (pa[28:26] == `UTF_AREA_6);
  endfunction

  assign stage_ent = unpack_words(entry_high_staging, entry_low_staging,
    entry_assist_staging);
  assign arr_ent = unpack_words(arr_hi, arr_lo, arr_as);
  assign use_tag = !single_space_select || user_mode;
  assign s_vfn = (fstate == utf_pkg::UTF_F_REFILL) ? f_addr[31:10] : d_vaddr[31:10];

  // Shared table storage and comparators, one per entry
  for (genvar i = 0; i < NS; i++) begin : g_shared
    utf_match_if mi ();
    assign mi.look_vfn = s_vfn;
    assign mi.look_tag = entry_high_staging[`UTF_HI_TAG_MSB:`UTF_HI_TAG_LSB];
    assign mi.use_tag = use_tag;
    assign mi.valid = s_valid[i];
    assign mi.ent = s_tab[i];
    assign s_hit[i] = mi.hit;
    utf_match u_match (
      .port(mi.cmp)
    );
    // Load op wins over an array write to the same slot
    always_ff @(posedge clk) begin
      if (clk_en) begin
        if (load_translation_op && (replace_pointer == 6'(i))) begin
          s_tab[i] <= stage_ent;
        end else if (arr_wr && !arr_fetch && (arr_idx == 6'(i))) begin
          s_tab[i] <= arr_ent;
        end
      end
    end
    // Valid bit survives manual reset; of the two resets only power-on clears it
    always_ff @(posedge clk) begin
      if (power_on_clear) begin
        s_valid[i] <= 1'b0;
      end else if (clk_en) begin
        if (load_translation_op && (replace_pointer == 6'(i))) begin
          s_valid[i] <= entry_low_staging[`UTF_LO_VALID];
        end else if ((arr_wr || arr_del) && !arr_fetch && (arr_idx == 6'(i))) begin
          s_valid[i] <= arr_wr && arr_lo[`UTF_LO_VALID];
        end
      end
    end
  end

  // Fetch table storage and comparators, one per entry
  for (genvar i = 0; i < NF; i++) begin : g_fetch
    utf_match_if mi ();
    assign mi.look_vfn = f_addr[31:10];
    assign mi.look_tag = entry_high_staging[`UTF_HI_TAG_MSB:`UTF_HI_TAG_LSB];
    assign mi.use_tag = use_tag;
    assign mi.valid = f_valid_bits[i];
    assign mi.ent = f_tab[i];
    assign f_hit[i] = mi.hit;
    utf_match u_match (
      .port(mi.cmp)
    );
    // Array writes win over a refill into the same slot
    always_ff @(posedge clk) begin
      if (clk_en) begin
        if (arr_wr && arr_fetch && (arr_idx[1:0] == 2'(i))) begin
          f_tab[i] <= fetch_form(arr_ent);
        end else if (refill_we && (victim == 2'(i))) begin
          f_tab[i] <= fetch_form(s_sel);
        end
      end
    end
    // Fetch valid bits follow the same reset split
    always_ff @(posedge clk) begin
      if (power_on_clear) begin
        f_valid_bits[i] <= 1'b0;
      end else if (clk_en) begin
        if ((arr_wr || arr_del) && arr_fetch && (arr_idx[1:0] == 2'(i))) begin
          f_valid_bits[i] <= arr_wr && arr_lo[`UTF_LO_VALID];
        end else if (refill_we && (victim == 2'(i))) begin
          f_valid_bits[i] <= 1'b1;
        end
      end
    end
  end

  // Select the matching shared entry and flag none or several
  always_comb begin
    s_sel = '0;
    for (int k = 0; k < NS; k++) begin
      if (s_hit[k]) begin
        s_sel = s_sel | s_tab[k];
      end
    end
    s_none = (s_hit == '0);
    s_multi = ((s_hit & (s_hit - 64'h1)) != '0);
  end

  // Select the matching fetch entry and its slot
  always_comb begin
    f_sel = '0;
    f_idx = 2'h0;
    for (int k = 0; k < NF; k++) begin
      if (f_hit[k]) begin
        f_sel = f_sel | f_tab[k];
        f_idx = 2'(k);
      end
    end
    f_none = (f_hit == '0);
    f_multi = ((f_hit & (f_hit - 4'h1)) != '0);
  end

  // Tree age bits name the slot to replace
  assign victim = fetch_table_age_bits[0] ? {1'b1, fetch_table_age_bits[2]}
    : {1'b0, fetch_table_age_bits[1]};

  // Access right checks for data and fetch
  assign d_prot = (user_mode && !s_sel.ar[1])
    || (d_write && !s_sel.ar[0]);
  assign f_prot = user_mode && !f_sel.ar[1];

  // Handshakes: data waits while the refill owns the shared compare
  assign d_ready = (fstate != utf_pkg::UTF_F_REFILL);
  assign f_ready = (fstate == utf_pkg::UTF_F_IDLE);
  assign d_take = d_req && d_ready && clk_en;
  assign f_take = f_req && f_ready && clk_en;
  assign d_untr = untranslated(d_vaddr, paging_enable_bit);
  assign f_untr = untranslated(f_addr, paging_enable_bit);
  assign refill_we = clk_en && (fstate == utf_pkg::UTF_F_REFILL) && !s_none && !s_multi;
  assign f_done = ((fstate == utf_pkg::UTF_F_LOOK) && (f_untr || !f_none))
    || ((fstate == utf_pkg::UTF_F_REFILL) && (s_none || s_multi));

  // Fetch sequencer: look, refill on miss, look again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fstate <= utf_pkg::UTF_F_IDLE;
      f_addr <= 32'h00000000;
    end else if (clk_en) begin
      case (fstate)
        utf_pkg::UTF_F_IDLE: begin
          if (f_take) begin
            f_addr <= f_vaddr;
            fstate <= utf_pkg::UTF_F_LOOK;
          end
        end
        utf_pkg::UTF_F_LOOK: begin
          if (f_done) begin
            fstate <= utf_pkg::UTF_F_IDLE;
          end else begin
            fstate <= utf_pkg::UTF_F_REFILL;
          end
        end
        utf_pkg::UTF_F_REFILL: begin
          if (f_done) begin
            fstate <= utf_pkg::UTF_F_IDLE;
          end else begin
            fstate <= utf_pkg::UTF_F_LOOK;
          end
        end
        default: begin
          fstate <= utf_pkg::UTF_F_IDLE;
        end
      endcase
    end
  end

  // Age bits point away from the slot last used or filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_table_age_bits <= `UTF_AGE_RESET;
    end else if (clk_en) begin
      if (refill_we) begin
        fetch_table_age_bits[0] <= !victim[1];
        if (victim[1]) begin
          fetch_table_age_bits[2] <= !victim[0];
        end else begin
          fetch_table_age_bits[1] <= !victim[0];
        end
      end else if ((fstate == utf_pkg::UTF_F_LOOK) && !f_untr && !f_none && !f_multi) begin
        fetch_table_age_bits[0] <= !f_idx[1];
        if (f_idx[1]) begin
          fetch_table_age_bits[2] <= !f_idx[0];
        end else begin
          fetch_table_age_bits[1] <= !f_idx[0];
        end
      end
    end
  end

  // Data answer one cycle after the request is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_valid <= 1'b0;
      d_paddr <= 29'h00000000;
      d_cacheable <= 1'b0;
      d_write_through <= 1'b0;
      d_space_attribute <= `UTF_SA_UNDEF;
      d_timing_select <= 1'b0;
      d_miss <= 1'b0;
      d_prot_viol <= 1'b0;
      d_multi_hit <= 1'b0;
      d_first_write <= 1'b0;
    end else if (clk_en) begin
      d_valid <= d_take;
      if (d_take) begin
        if (d_untr) begin
          d_paddr <= d_vaddr[28:0];
          d_cacheable <= (d_vaddr[31:29] != `UTF_REG_P2);
          d_write_through <= 1'b0;
          d_space_attribute <= `UTF_SA_UNDEF;
          d_timing_select <= 1'b0;
          d_miss <= 1'b0;
          d_prot_viol <= 1'b0;
          d_multi_hit <= 1'b0;
          d_first_write <= 1'b0;
        end else begin
          d_paddr <= phys(s_sel, d_vaddr);
          d_cacheable <= s_sel.cacheable;
          d_write_through <= s_sel.wt;
          d_space_attribute <= card_area(phys(s_sel, d_vaddr)) ? s_sel.sa
            : `UTF_SA_UNDEF;
          d_timing_select <= card_area(phys(s_sel, d_vaddr)) && s_sel.ts;
          d_multi_hit <= s_multi;
          d_miss <= s_none;
          d_prot_viol <= !s_none && !s_multi && d_prot;
          d_first_write <= !s_none && !s_multi && !d_prot
            && d_write && !s_sel.written;
        end
      end
    end
  end

  // Fetch answer when the sequencer finishes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_valid <= 1'b0;
      f_paddr <= 29'h00000000;
      f_cacheable <= 1'b0;
      f_miss <= 1'b0;
      f_prot_viol <= 1'b0;
      f_multi_hit <= 1'b0;
    end else if (clk_en) begin
      f_valid <= f_done;
      if (f_done) begin
        if (fstate == utf_pkg::UTF_F_REFILL) begin
          f_paddr <= f_addr[28:0];
          f_cacheable <= 1'b0;
          f_miss <= s_none && !s_multi;
          f_multi_hit <= s_multi;
          f_prot_viol <= 1'b0;
        end else if (f_untr) begin
          f_paddr <= f_addr[28:0];
          f_cacheable <= (f_addr[31:29] != `UTF_REG_P2);
          f_miss <= 1'b0;
          f_multi_hit <= 1'b0;
          f_prot_viol <= 1'b0;
        end else begin
          f_paddr <= phys(f_sel, f_addr);
          f_cacheable <= f_sel.cacheable;
          f_miss <= 1'b0;
          f_multi_hit <= f_multi;
          f_prot_viol <= !f_multi && f_prot;
        end
      end
    end
  end

  // Array read back one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_rd_valid <= 1'b0;
      arr_rd_hi <= 32'h00000000;
      arr_rd_lo <= 32'h00000000;
      arr_rd_as <= 32'h00000000;
    end else if (clk_en) begin
      arr_rd_valid <= arr_rd;
      if (arr_rd) begin
        if (arr_fetch) begin
          arr_rd_hi <= {f_tab[arr_idx[1:0]].vfn, 2'h0, f_tab[arr_idx[1:0]].tag};
          arr_rd_lo <= {3'h0, f_tab[arr_idx[1:0]].pfn, 1'b0,
            f_valid_bits[arr_idx[1:0]], f_tab[arr_idx[1:0]].size,
            f_tab[arr_idx[1:0]].ar, f_tab[arr_idx[1:0]].cacheable,
            1'b0, f_tab[arr_idx[1:0]].common, 1'b0};
          arr_rd_as <= {28'h0000000, f_tab[arr_idx[1:0]].sa, f_tab[arr_idx[1:0]].ts};
        end else begin
          arr_rd_hi <= {s_tab[arr_idx].vfn, 2'h0, s_tab[arr_idx].tag};
          arr_rd_lo <= {3'h0, s_tab[arr_idx].pfn, 1'b0, s_valid[arr_idx],
            s_tab[arr_idx].size, s_tab[arr_idx].ar, s_tab[arr_idx].cacheable,
            s_tab[arr_idx].written, s_tab[arr_idx].common, s_tab[arr_idx].wt};
          arr_rd_as <= {28'h0000000, s_tab[arr_idx].sa, s_tab[arr_idx].ts};
        end
      end
    end
  end

  // Any exception on a finished answer
  assign mmu_exception = (d_valid && (d_miss || d_prot_viol || d_multi_hit || d_first_write))
    || (f_valid && (f_miss || f_prot_viol || f_multi_hit));
endmodule
`default_nettype wire

// *** test/utf_translate_chk.sv ***
// Port timing checks for the translation buffers
`default_nettype none
module utf_translate_chk (
  // Clock and control
  input wire logic clk, rst_n, clk_en, paging_enable_bit,
  // Data side
  input wire logic d_req, d_ready, d_valid, d_miss, d_prot_viol, d_multi_hit,
  input wire logic d_timing_select, mmu_exception,
  input wire logic [31:0] d_vaddr,
  input wire logic [28:0] d_paddr,
  input wire logic [2:0] d_space_attribute,
  // Fetch side
  input wire logic f_req, f_ready, f_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Data answers follow their request by one cycle
  d_lat_a: assert property (d_req && d_ready && clk_en |=> d_valid)
    else $error("data answer missing");
  d_idle_a: assert property (!d_req |=> !d_valid)
    else $error("data answer without request");
  // Paging off passes the address straight through
  bypass_addr_a: assert property (d_valid && !$past(paging_enable_bit)
    |-> d_paddr == 29'($past(d_vaddr)) && !d_miss)
    else $error("bypass address wrong");
  multi_prio_a: assert property (d_valid && d_multi_hit |-> !d_miss && !d_prot_viol)
    else $error("multiple hit not first");
  // Card attributes only reach areas 5 and 6
  card_attr_a: assert property (d_valid && !(d_paddr[28:26] inside {3'h5, 3'h6})
    |-> d_space_attribute == 3'h0 && !d_timing_select)
    else $error("attribute outside card area");
  miss_paged_a: assert property (d_valid && d_miss |-> $past(paging_enable_bit))
    else $error("miss with paging off");
  miss_exc_a: assert property (d_valid && d_miss |-> mmu_exception)
    else $error("miss without exception");
  // Fetch handshake and answer window
  f_busy_a: assert property (f_req && f_ready && clk_en |=> !f_ready)
    else $error("fetch ready while busy");
  f_lat_a: assert property (f_req && f_ready && clk_en |-> ##[2:4] f_valid)
    else $error("fetch answer late");
  refill_busy_a: assert property (!d_ready |-> !f_ready)
    else $error("data refused outside refill");
endmodule
`default_nettype wire

// *** test/utf_core_model.sv ***
// Fetch unit model issuing one instruction fetch per command
`default_nettype none
module utf_core_model (
  // Command from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] addr,
  // Fetch handshake
  input wire logic f_ready,
  output logic f_req = 1'b0,
  output logic [31:0] f_vaddr = 32'h0
);
  logic took = 1'b0;
  // Note the edge that took the request
  always @(posedge clk) took <= f_req && f_ready;
  // Raise on command, drop once taken
  always @(negedge clk) begin
    if (took) begin
      f_req <= 1'b0;
      f_vaddr <= ~f_vaddr; // Released address must not look stale
    end else if (go && !f_req) begin
      f_req <= 1'b1;
      f_vaddr <= addr;
    end
  end
endmodule
`default_nettype wire

// *** test/utf_translate_test.sv ***
// Self-checking bench for the translation buffers
`default_nettype none
module utf_translate_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VA = 32'h0123_4567;
  logic clk = 0, rst_n = 0, clk_en = 1, power_on_clear = 1, paging_enable_bit = 1, go = 0;
  logic single_space_select = 0, user_mode = 0, load_translation_op = 0, d_req = 0;
  logic d_write = 0, arr_wr = 0, arr_del = 0, arr_rd = 0, arr_fetch = 0;
  logic [31:0] entry_high_staging = 0, entry_low_staging = 0, entry_assist_staging = 0;
  logic [31:0] arr_hi = 0, arr_lo = 0, arr_as = 0, d_vaddr = 0, fa = 0, f_vaddr;
  logic [31:0] arr_rd_hi, arr_rd_lo, arr_rd_as;
  logic [5:0] replace_pointer = 0, arr_idx = 0;
  logic [28:0] d_paddr, f_paddr;
  logic [2:0] d_space_attribute, fetch_table_age_bits;
  logic arr_rd_valid, d_ready, d_valid, d_cacheable, d_write_through, d_timing_select;
  logic d_miss, d_prot_viol, d_multi_hit, d_first_write, f_req, f_ready, f_valid;
  logic f_cacheable, f_miss, f_prot_viol, f_multi_hit, mmu_exception;
  int fail_count = 0, compares = 0;
  utf_translate dut (.*);
  utf_core_model core (.clk, .go, .addr(fa), .f_ready, .f_req, .f_vaddr);
  initial forever #2 clk = ~clk;
  // Value compare
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("Compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] lo(input logic [18:0] p, input logic [1:0] z, r,
    input logic [3:0] f);
    return {3'h0, p, 2'h1, z, r, f}; // Flags are cache, written, common, write-through
  endfunction
  function automatic logic [31:0] hi(input logic [31:0] v, input logic [7:0] t = 8'h22);
    return {v[31:10], 2'h0, t};
  endfunction
  // Load op from untranslated code
  task automatic ld(input logic [5:0] s, input logic [31:0] h, l, a = 0);
    @(negedge clk);
    {replace_pointer, entry_high_staging, entry_low_staging, entry_assist_staging} = {s, h, l, a};
    load_translation_op = 1;
    @(negedge clk);
    load_translation_op = 0;
  endtask
  // One data lookup; answer is checked in its cycle
  task automatic dl(input logic [31:0] va, input logic w = 0);
    @(negedge clk);
    {d_req, d_vaddr, d_write} = {1'b1, va, w};
    @(negedge clk);
    {d_req, d_vaddr} = {1'b0, ~va};
    chk("d_valid", 1, d_valid);
  endtask
  // One fetch; counts cycles to its answer
  task automatic fe(input logic [31:0] va, input int n);
    int k = 0;
    @(negedge clk);
    go <= 1;
    fa <= va;
    @(negedge clk);
    go <= 0;
    while (f_valid !== 1'b1 && k < 9) begin
      @(negedge clk);
      k++;
    end
    chk("fetch cycles", n, k);
  endtask
  // One array pulse: k is {read, delete, write}
  task automatic ar(input logic [2:0] k, input logic f, input logic [5:0] i,
    input logic [31:0] h, l);
    @(negedge clk);
    {arr_rd, arr_del, arr_wr, arr_fetch, arr_idx, arr_hi, arr_lo} = {k, f, i, h, l};
    @(negedge clk);
    {arr_rd, arr_del, arr_wr, arr_hi, arr_lo} = {3'h0, ~h, ~l};
  endtask
  // Page sizes; one entry per frame, so no synonyms
  task automatic t_size;
    int w[4] = '{10, 12, 16, 20};
    logic [28:0] m;
    for (int s = 0; s < 4; s++) begin
      m = (29'h1 << w[s]) - 29'h1;
      ld(0, hi(VA), lo(19'h1_4321, 2'(s), 2'h3, 4'h8));
      dl(VA);
      chk("paddr", ({19'h1_4321, 10'h0} & ~m) | (VA[28:0] & m), d_paddr);
      dl(VA ^ (32'h1 << w[s]));
      chk("frame miss", 1, d_miss);
    end
    $display("size test done");
  endtask
  // Access right codes against mode and direction
  task automatic t_prot;
    logic [1:0] a;
    logic u, w;
    for (int i = 0; i < 16; i++) begin
      {a, u, w} = 4'(i);
      ld(0, hi(VA), lo(19'h1_4321, 2'h3, a, 4'hC));
      user_mode = u;
      dl(VA, w);
      chk("prot", (u & ~a[1]) | (w & ~a[0]), d_prot_viol);
      chk("exception", (u & ~a[1]) | (w & ~a[0]), mmu_exception);
    end
    user_mode = 0;
    $display("protection test done");
  endtask
  // Process tag compare; rows are {single, user, common, miss}
  task automatic t_tag;
    logic [3:0] t[5] = '{4'h1, 4'h2, 4'h8, 4'hD, 4'hE};
    for (int i = 0; i < 5; i++) begin
      ld(0, hi(VA, 8'h11), lo(19'h1_4321, 2'h3, 2'h3, {2'h2, t[i][1], 1'b0}));
      {single_space_select, user_mode} = t[i][3:2];
      entry_high_staging[7:0] = 8'h22;
      dl(VA);
      chk("tag miss", t[i][0], d_miss);
    end
    {single_space_select, user_mode} = 2'h0;
    $display("tag test done");
  endtask
  // Cache mode and card attributes, area 5 against area 0
  task automatic t_attr;
    for (int k = 0; k < 2; k++) begin
      ld(0, hi(VA), lo(k ? 19'h5_0000 : 19'h0, 2'h3, 2'h3, k ? 4'h1 : 4'hA), 32'h7);
      dl(VA, 1);
      chk("attr", k ? 6'h17 : 6'h20,
        {d_cacheable, d_write_through, d_space_attribute, d_timing_select});
      chk("first write", 1, d_first_write);
    end
    $display("attribute test done");
  endtask
  // Refill, reload, shared miss, protection
  task automatic t_fetch;
    ld(5, hi(32'h0040_0000), lo(19'h0_0C00, 2'h3, 2'h2, 4'h8));
    fe(32'h0040_1234, 4);
    chk("f_paddr", 29'h0030_1234, f_paddr);
    ld(5, hi(32'h0040_0000), lo(19'h0_7C00, 2'h3, 2'h2, 4'h8));
    fe(32'h0040_1234, 2);
    chk("f_paddr kept", 29'h0030_1234, f_paddr);
    fe(32'h0080_0000, 3);
    chk("f_miss", 2'h3, {f_miss, mmu_exception});
    ld(63, hi(32'h0100_0000), lo(19'h0_0C00, 2'h3, 2'h1, 4'h8));
    user_mode = 1;
    fe(32'h0100_0000, 4);
    chk("f_prot", 1, f_prot_viol);
    user_mode = 0;
    $display("fetch test done");
  endtask
  // Array write, read, delete; fetch entry by array
  task automatic t_array;
    ar(3'h1, 0, 9, hi(32'h0200_0000), lo(19'h0_0400, 2'h3, 2'h3, 4'h8));
    dl(32'h0200_0010);
    chk("array hit", 29'h0010_0010, d_paddr);
    ar(3'h4, 0, 9, 0, 0);
    chk("read valid", 1, arr_rd_valid);
    chk("read low", lo(19'h0_0400, 2'h3, 2'h3, 4'h8), arr_rd_lo);
    chk("read high", hi(32'h0200_0000), arr_rd_hi);
    ar(3'h2, 0, 9, 0, 0);
    dl(32'h0200_0010);
    chk("deleted", 1, d_miss);
    ar(3'h1, 1, 0, hi(32'h0300_0000), lo(19'h0_0800, 2'h3, 2'h3, 4'h8));
    fe(32'h0300_0000, 2);
    chk("array fetch", 29'h0020_0000, f_paddr);
    $display("array test done");
  endtask
  // Manual reset keeps, power-on clear drops, double hit, bypass
  task automatic t_reset;
    ld(0, hi(VA), lo(19'h1_4321, 2'h3, 2'h3, 4'hC));
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    dl(VA);
    chk("kept", 0, d_miss);
    power_on_clear = 1;
    @(negedge clk);
    power_on_clear = 0;
    dl(VA);
    chk("cleared", 1, d_miss);
    ld(0, hi(VA), lo(19'h1_4321, 2'h3, 2'h3, 4'hC));
    ld(1, hi(VA), lo(19'h1_4321, 2'h3, 2'h3, 4'hC));
    dl(VA);
    chk("multi hit", 1, d_multi_hit);
    paging_enable_bit = 0;
    dl(VA);
    chk("bypass", VA[28:0], d_paddr);
    $display("reset test done");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    power_on_clear = 0;
    t_size;
    t_prot;
    t_tag;
    t_attr;
    t_fetch;
    t_array;
    t_reset;
    close_out;
  end
  // Watchdog
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule
bind utf_translate utf_translate_chk chk (.*);
`default_nettype wire
